// *** rem_rail_regs.sv ***
// Rail enable and buck mode registers with the rail power sequencer.
// Functional notes
// - Enable bit 7 turns the load switch off at zero, on at one.
// - After power-up the device itself sets every rail enable bit to one.
// - Writing zero to bit 7 once the sequence has finished turns rails off and clears the register.
// - Writing one to bit 7 after shutdown re-powers rails in sequence.
// - Enable bit 6 disables or enables the core buck.
// - Enable bit 5 disables or enables the memory buck.
// - Enable bit 4 disables or enables the flash interface buck.
// - Enable bit 3 disables or enables the linear regulator.
// - Enable bit 2 drives the first external enable output.
// - Enable bit 1 drives the second external enable output.
// - Enable bits 7 to 1 are read-write; bit 0 is reserved, read-only.
// - Mode bit 7 picks pulse-skip or forced PWM for the core buck.
// - Mode bit 6 picks pulse-skip or forced PWM for the memory buck.
// - Mode bit 5 picks pulse-skip or forced PWM for the flash buck.
`timescale 1ns/1ns
module rem_rail_regs
    import rem_pkg::*;
#(
    parameter int STEP_CYCLES = REM_SEQ_STEP_CYCLES
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic calib_done,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic load_switch_on,
    output logic core_buck_enable,
    output logic memory_buck_enable,
    output logic flash_io_buck_enable,
    output logic linear_regulator_enable,
    output logic external_enable_out_a,
    output logic external_enable_out_b,
    output logic core_buck_forced_pwm,
    output logic memory_buck_forced_pwm,
    output logic flash_io_buck_forced_pwm,
    output logic sequence_busy
);

    rem_state_t state;
    logic [7:0] rail_enable_control;
    logic [7:0] buck_mode_control;
    logic [2:0] seq_bit;
    logic [15:0] step_cnt;
    logic cal_meta;
    logic cal_sync;
    logic step_done;
    logic enable_wr;
    logic mode_wr;

    function automatic logic [7:0] rem_read(input logic [7:0] addr,
                                            input logic [7:0] en,
                                            input logic [7:0] md);
        logic [7:0] value;
        value = REM_UNMAPPED_READ;
        if (addr == REM_ENABLE_OFFSET)
        begin
            value = en & REM_ENABLE_WR_MASK;
        end
        else if (addr == REM_MODE_OFFSET)
        begin
            value = md & REM_MODE_WR_MASK;
        end
        return value;
    endfunction

    assign step_done = (step_cnt == 16'(STEP_CYCLES - 1));
    assign enable_wr = reg_wr && (reg_addr == REM_ENABLE_OFFSET);
    assign mode_wr = reg_wr && (reg_addr == REM_MODE_OFFSET);

    // Calibration status comes from the analog side and is synchronised.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cal_meta <= 1'b0;
            cal_sync <= 1'b0;
        end
        else
        begin
            cal_meta <= calib_done;
            cal_sync <= cal_meta;
        end
    end

    // Sequencer: rails come up one per step once calibration is done.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= REM_SEQ;
            sequence_busy <= 1'b1;
            seq_bit <= REM_SEQ_FIRST;
            step_cnt <= 16'h0000;
        end
        else
        begin
            case (state)
                REM_SEQ:
                begin
                    if (cal_sync)
                    begin
                        if (step_done)
                        begin
                            step_cnt <= 16'h0000;
                            if (seq_bit == REM_SEQ_LAST)
                            begin
                                state <= REM_ON;
                                sequence_busy <= 1'b0;
                            end
                            else
                            begin
                                seq_bit <= seq_bit - 3'h1;
                            end
                        end
                        else
                        begin
                            step_cnt <= step_cnt + 16'h0001;
                        end
                    end
                end
                REM_ON:
                begin
                    if (enable_wr && !reg_wdata[REM_LSW_BIT])
                    begin
                        state <= REM_OFF;
                    end
                end
                REM_OFF:
                begin
                    if (enable_wr && reg_wdata[REM_LSW_BIT])
                    begin
                        state <= REM_SEQ;
                        sequence_busy <= 1'b1;
                        seq_bit <= REM_SEQ_FIRST;
                        step_cnt <= 16'h0000;
                    end
                end
                default:
                begin
                    state <= REM_OFF;
                    sequence_busy <= 1'b0;
                end
            endcase
        end
    end

    // Enable register: sequencer fills it, host edits it while rails run.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rail_enable_control <= REM_ENABLE_RESET;
        end
        else if (state == REM_SEQ && cal_sync && step_done)
        begin
            rail_enable_control[seq_bit] <= 1'b1;
        end
        else if (state == REM_ON && enable_wr)
        begin
            if (!reg_wdata[REM_LSW_BIT])
            begin
                rail_enable_control <= REM_ENABLE_RESET;
            end
            else
            begin
                rail_enable_control <= reg_wdata & REM_ENABLE_WR_MASK;
            end
        end
    end

    // Mode register: forced PWM or pulse-skip per buck channel.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            buck_mode_control <= REM_MODE_RESET;
        end
        else if (mode_wr)
        begin
            buck_mode_control <= reg_wdata & REM_MODE_WR_MASK;
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= REM_UNMAPPED_READ;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rem_read(reg_addr, rail_enable_control,
                                  buck_mode_control);
        end
    end

    assign load_switch_on = rail_enable_control[REM_LSW_BIT];
    assign core_buck_enable = rail_enable_control[REM_CORE_BIT];
    assign memory_buck_enable = rail_enable_control[REM_MEM_BIT];
    assign flash_io_buck_enable = rail_enable_control[REM_FLASH_BIT];
    assign linear_regulator_enable = rail_enable_control[REM_LIN_BIT];
    assign external_enable_out_a = rail_enable_control[REM_EXTA_BIT];
    assign external_enable_out_b = rail_enable_control[REM_EXTB_BIT];
    assign core_buck_forced_pwm =
        buck_mode_control[REM_CORE_PWM_BIT];
    assign memory_buck_forced_pwm =
        buck_mode_control[REM_MEM_PWM_BIT];
    assign flash_io_buck_forced_pwm =
        buck_mode_control[REM_FLASH_PWM_BIT];

    a_lsw_readback: assert property (
        @(posedge core_clk) disable iff (reset)
        reg_rd && reg_addr == REM_ENABLE_OFFSET
        |=> reg_rdata[REM_LSW_BIT] == $past(load_switch_on))
        else $error("Load switch readback does not match the pin.");

    a_powerup_fill: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_SEQ ##1 state == REM_ON
        |-> rail_enable_control == REM_ALL_RAILS_ON)
        else $error("Sequence ended without every enable set.");

    a_shutdown_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_ON && enable_wr && !reg_wdata[REM_LSW_BIT]
        |=> rail_enable_control == 8'h00 && !load_switch_on
            && !core_buck_enable && state == REM_OFF)
        else $error("Shutdown did not clear the enable register.");

    a_restart_order: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(core_buck_enable) |-> load_switch_on
            && (sequence_busy || $past(enable_wr)))
        else $error("Core buck rose without the sequence or a write.");

    a_restart_start: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_OFF && enable_wr && reg_wdata[REM_LSW_BIT]
        |=> state == REM_SEQ && rail_enable_control == 8'h00)
        else $error("Restart write did not start the sequence.");

    a_core_write: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_ON && enable_wr && reg_wdata[REM_LSW_BIT]
        |=> core_buck_enable == $past(reg_wdata[REM_CORE_BIT]))
        else $error("Core buck enable did not follow the write.");

    a_mem_flash_write: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_ON && enable_wr && reg_wdata[REM_LSW_BIT]
        |=> memory_buck_enable == $past(reg_wdata[REM_MEM_BIT])
            && flash_io_buck_enable == $past(reg_wdata[REM_FLASH_BIT]))
        else $error("Memory or flash buck enable did not follow the write.");

    a_ldo_ext_write: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_ON && enable_wr && reg_wdata[REM_LSW_BIT]
        |=> {linear_regulator_enable, external_enable_out_a,
             external_enable_out_b} == $past(reg_wdata[3:1]))
        else $error("Regulator or external enable did not follow the write.");

    a_reserved_zero: assert property (
        @(posedge core_clk) disable iff (reset)
        reg_rd && reg_addr == REM_ENABLE_OFFSET
        |=> reg_rdata[REM_RSVD_BIT] == 1'b0)
        else $error("Reserved enable bit read as one.");

    a_mode_write: assert property (
        @(posedge core_clk) disable iff (reset)
        mode_wr |=> {core_buck_forced_pwm, memory_buck_forced_pwm,
                     flash_io_buck_forced_pwm} == $past(reg_wdata[7:5]))
        else $error("Buck mode outputs did not follow the write.");

    a_off_stays_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        state == REM_OFF |-> rail_enable_control == 8'h00)
        else $error("Enable register not clear while rails are off.");

    a_seq_rail_order: assert property (
        @(posedge core_clk) disable iff (reset)
        sequence_busy && $rose(memory_buck_enable)
        |-> core_buck_enable && load_switch_on)
        else $error("Memory buck came up before the core buck.");

    a_calib_wait: assert property (
        @(posedge core_clk) disable iff (reset)
        sequence_busy && !cal_sync |=> $stable(rail_enable_control))
        else $error("Rails changed before calibration finished.");

    a_busy_end_full: assert property (
        @(posedge core_clk) disable iff (reset)
        $fell(sequence_busy) |-> rail_enable_control == REM_ALL_RAILS_ON)
        else $error("Sequencer went idle with an enable still clear.");

endmodule // rem_rail_regs

// *** rem_pkg.sv ***
// Constants and types for the rail enable and buck mode register bank.
package rem_pkg;

    localparam logic [7:0] REM_ENABLE_OFFSET = 8'h03;
    localparam logic [7:0] REM_MODE_OFFSET = 8'h04;
    localparam logic [7:0] REM_ENABLE_RESET = 8'h00;
    localparam logic [7:0] REM_MODE_RESET = 8'h00;
    localparam logic [7:0] REM_ENABLE_WR_MASK = 8'hFE;
    localparam logic [7:0] REM_MODE_WR_MASK = 8'hE0;
    localparam logic [7:0] REM_ALL_RAILS_ON = 8'hFE;
    localparam logic [7:0] REM_UNMAPPED_READ = 8'h00;

    localparam int REM_LSW_BIT = 7;
    localparam int REM_CORE_BIT = 6;
    localparam int REM_MEM_BIT = 5;
    localparam int REM_FLASH_BIT = 4;
    localparam int REM_LIN_BIT = 3;
    localparam int REM_EXTA_BIT = 2;
    localparam int REM_EXTB_BIT = 1;
    localparam int REM_RSVD_BIT = 0;

    localparam int REM_CORE_PWM_BIT = 7;
    localparam int REM_MEM_PWM_BIT = 6;
    localparam int REM_FLASH_PWM_BIT = 5;

    localparam logic [2:0] REM_SEQ_FIRST = 3'h7;
    localparam logic [2:0] REM_SEQ_LAST = 3'h1;

    localparam int REM_CLK_MHZ = 20;
    localparam int REM_SEQ_STEP_NS = 10000;
    localparam int REM_SEQ_STEP_CYCLES = (REM_SEQ_STEP_NS * REM_CLK_MHZ
        + 999) / 1000;

    typedef enum logic [1:0] {REM_OFF, REM_SEQ, REM_ON} rem_state_t;

endpackage

// *** rem_host_model.sv ***
// Host model that reaches the register bank by single byte accesses.
`timescale 1ns/1ns
module rem_host_model
(
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One write strobe; data is inverted once the strobe is released.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~data;
    endtask

    // One read strobe; the byte is taken a cycle after the strobe edge.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        #1;
        data = reg_rdata;
    endtask

    // The host restarts the rails with the load switch bit alone.
    task automatic restart_rails();
        write_reg(8'h03, 8'h80);
    endtask
endmodule // rem_host_model

// *** tb_top.sv ***
// Self-checking testbench for the rail enable and buck mode registers.
`timescale 1ns/1ns
`define CHECK_EQ(act, exp) begin check_count++; if ((act) !== (exp)) begin \
    miscompares++; $display("[ERR] %0t got %h expected %h", $time, act, \
    exp); end end
module tb_top;
    import rem_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic calib_done = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, exp;
    logic reg_wr, reg_rd, sequence_busy;
    wire [6:0] rails;
    wire [2:0] pwm;
    int miscompares = 0;
    int check_count = 0;
    int i;

    always #25 core_clk = ~core_clk;

    rem_rail_regs #(.STEP_CYCLES(3)) i_rem_rail_regs (.core_clk(core_clk),
        .reset(reset), .calib_done(calib_done), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .load_switch_on(rails[6]),
        .core_buck_enable(rails[5]), .memory_buck_enable(rails[4]),
        .flash_io_buck_enable(rails[3]),
        .linear_regulator_enable(rails[2]),
        .external_enable_out_a(rails[1]), .external_enable_out_b(rails[0]),
        .core_buck_forced_pwm(pwm[2]), .memory_buck_forced_pwm(pwm[1]),
        .flash_io_buck_forced_pwm(pwm[0]), .sequence_busy(sequence_busy));

    rem_host_model i_rem_host_model (.core_clk(core_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_rem_host_model.write_reg(addr, data);
        #1;
    endtask

    task automatic chk_reg(input logic [7:0] addr, input logic [7:0] value);
        i_rem_host_model.read_reg(addr, rd);
        `CHECK_EQ(rd, value)
    endtask

    // Waits a bounded time for the power sequencer to finish.
    task automatic wait_idle();
        int n;
        for (n = 0; n < 200 && sequence_busy !== 1'b0; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        if (n == 200)
        begin
            miscompares++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial
    begin
        repeat (15) @(posedge core_clk);
        #1;
        `CHECK_EQ(rails, 7'h00)
        @(posedge core_clk);
        reset <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        `CHECK_EQ(rails, 7'h00)
        @(posedge core_clk);
        calib_done <= 1'b1;
        wait_idle();
        `CHECK_EQ(rails, 7'h7F)
        chk_reg(REM_ENABLE_OFFSET, 8'hFE);
        chk_reg(REM_MODE_OFFSET, REM_MODE_RESET);
        chk_reg(8'h05, REM_UNMAPPED_READ);
        $display("power-up test done");
        for (i = 1; i < 7; i++)
        begin
            exp = 8'hFE & ~(8'h01 << i);
            wr(REM_ENABLE_OFFSET, exp | 8'h01);
            `CHECK_EQ(rails, exp[7:1])
            chk_reg(REM_ENABLE_OFFSET, exp);
        end
        wr(REM_ENABLE_OFFSET, 8'hFF);
        chk_reg(REM_ENABLE_OFFSET, 8'hFE);
        $display("enable bit test done");
        for (i = 5; i < 8; i++)
        begin
            wr(REM_MODE_OFFSET, (8'h01 << i) | 8'h1F);
            `CHECK_EQ(pwm, 3'h1 << (i - 5))
            chk_reg(REM_MODE_OFFSET, 8'h01 << i);
        end
        wr(REM_MODE_OFFSET, 8'hFF);
        `CHECK_EQ(pwm, 3'h7)
        $display("mode test done");
        wr(REM_ENABLE_OFFSET, 8'h7E);
        `CHECK_EQ(rails, 7'h00)
        chk_reg(REM_ENABLE_OFFSET, 8'h00);
        wr(REM_ENABLE_OFFSET, 8'h7E);
        chk_reg(REM_ENABLE_OFFSET, 8'h00);
        i_rem_host_model.restart_rails();
        #1;
        `CHECK_EQ(sequence_busy, 1'b1)
        wait_idle();
        `CHECK_EQ(rails, 7'h7F)
        chk_reg(REM_ENABLE_OFFSET, REM_ALL_RAILS_ON);
        $display("shutdown and restart test done");
        end_sim();
    end

    initial
    begin
        #(50 * 5000);
        miscompares++;
        end_sim();
    end
endmodule // tb_top
